// File: hdl/tgx_sync.sv
/*
  Two flip-flop synchroniser bank with falling-edge and level outputs.
  Assumes asynchronous pin inputs and one clock, synchronous active-high reset.
*/
`timescale 1ns/1ps
module tgx_sync
  import tgx_pkg::*;
#(
  parameter int WIDTH = TGX_SYNC_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stable;

  // -------------------------------------------------------------
  // two stages, then a delayed copy for edge detection
  // -------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta[g] <= 1'b1;  // idle-high pins
          stable[g] <= 1'b1;
          level[g] <= 1'b1;
        end else begin
          meta[g] <= pin[g];
          stable[g] <= meta[g];
          level[g] <= stable[g];
        end
      end
      // one pulse per high-to-low transition
      assign fall[g] = level[g] & ~stable[g];
    end
  endgenerate

endmodule

// File: hdl/tgx_timer.sv
/*
  One 16-bit timer/counter with gate and external count input.
  Assumes synchronised gate level and count falling-edge pulse from tgx_sync.
*/
`timescale 1ns/1ps
module tgx_timer
  import tgx_pkg::*;
#(
  parameter int CNT_W = TGX_CNT_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire tgx_tcfg_t cfg,
  input wire logic gate_level,
  input wire logic count_fall,
  input wire logic load,
  input wire logic [CNT_W-1:0] load_value,
  output logic [CNT_W-1:0] count,
  output tgx_tevt_t evt
);

  // -------------------------------------------------------------
  // run and tick selection
  // -------------------------------------------------------------
  wire run_ok = cfg.run & (~cfg.gate_sel | gate_level);
  wire tick = run_ok & (cfg.counter_mode ? count_fall : 1'b1);
  wire [CNT_W:0] next_sum = {1'b0, count} + {{CNT_W{1'b0}}, 1'b1};

  // count register; software load wins over a tick
  always_ff @(posedge clk) begin
    if (rst) begin
      count <= '0;
      evt <= '0;
    end else begin
      evt.overflow <= tick & ~load & next_sum[CNT_W];
      if (load) begin
        count <= load_value;
      end else if (tick) begin
        count <= next_sum[CNT_W-1:0];
      end
    end
  end

  a_gate_blocks_count: assert property (@(posedge clk) disable iff (rst)
    (cfg.gate_sel && !gate_level && !load) |=> $stable(count))
    else $error("count moved while gate low");
  a_counter_step_one: assert property (@(posedge clk) disable iff (rst)
    (cfg.counter_mode && run_ok && count_fall && !load) |=> (count == $past(count) + 1'b1))
    else $error("counter missed a falling edge");
  a_counter_no_edge: assert property (@(posedge clk) disable iff (rst)
    (cfg.counter_mode && !count_fall && !load) |=> $stable(count))
    else $error("counter advanced without an edge");

endmodule

// File: hdl/tgx_top.sv
/*
  Timer gate and external interrupt input block with APB register file.
  Two 16-bit timers, two interrupt pins with edge/level trigger, sticky
  status with mask and one level interrupt output.
  Assumes a 100 MHz CLK, synchronous active-high RST, a standard APB master.
*/
`timescale 1ns/1ps

module tgx_top
  import tgx_pkg::*;
(
  input wire logic CLK,
  input wire logic RST,
  input wire logic EXT_IRQ0_IN,
  input wire logic EXT_IRQ1_IN,
  input wire logic TIMER0_COUNT_IN,
  input wire logic TIMER1_COUNT_IN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [TGX_ADDR_W-1:0] PADDR,
  input wire logic [TGX_DATA_W-1:0] PWDATA,
  output logic [TGX_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [TGX_SYNC_W-1:0] pin_level;
  logic [TGX_SYNC_W-1:0] pin_fall;

  tgx_sync #(.WIDTH(TGX_SYNC_W)) u_sync (
    .clk(CLK),
    .rst(RST),
    .pin({TIMER1_COUNT_IN, TIMER0_COUNT_IN, EXT_IRQ1_IN, EXT_IRQ0_IN}),
    .level(pin_level),
    .fall(pin_fall)
  );

  // pin index map inside the bank
  wire irq0_level = pin_level[0];
  wire irq1_level = pin_level[1];
  wire irq0_fall = pin_fall[0];
  wire irq1_fall = pin_fall[1];
  wire t0_fall = pin_fall[2];
  wire t1_fall = pin_fall[3];

  // ----------------------------------------------------------------
  // register file state
  // ----------------------------------------------------------------
  logic [TGX_CTRL_W-1:0] timer_control_reg;
  logic [TGX_STAT_W-1:0] status;
  logic [TGX_STAT_W-1:0] mask;
  logic [TGX_CNT_W-1:0] count0;
  logic [TGX_CNT_W-1:0] count1;
  tgx_tevt_t evt0;
  tgx_tevt_t evt1;

  // named control fields
  wire irq0_edge_sel = timer_control_reg[TGX_B_IT0];
  wire irq1_edge_sel = timer_control_reg[TGX_B_IT1];
  wire timer0_gate_sel = timer_control_reg[TGX_B_TIMER0_GATE_SEL];
  wire timer1_gate_sel = timer_control_reg[TGX_B_TIMER1_GATE_SEL];

  tgx_tcfg_t cfg0;
  tgx_tcfg_t cfg1;
  assign cfg0 = '{run: timer_control_reg[TGX_B_RUN0], counter_mode: timer_control_reg[TGX_B_CT0],
                  gate_sel: timer0_gate_sel};
  assign cfg1 = '{run: timer_control_reg[TGX_B_RUN1], counter_mode: timer_control_reg[TGX_B_CT1],
                  gate_sel: timer1_gate_sel};

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire access = PSEL & PENABLE & ~PREADY;
  wire wr_en = access & PWRITE;
  wire sel_ctrl = (PADDR == TGX_OFF_CTRL);
  wire sel_stat = (PADDR == TGX_OFF_STAT);
  wire sel_mask = (PADDR == TGX_OFF_MASK);
  wire sel_cnt0 = (PADDR == TGX_OFF_CNT0);
  wire sel_cnt1 = (PADDR == TGX_OFF_CNT1);
  wire sel_pins = (PADDR == TGX_OFF_PINS);
  wire mapped = sel_ctrl | sel_stat | sel_mask | sel_cnt0 | sel_cnt1 | sel_pins;
  wire load0 = wr_en & sel_cnt0;  // software count loads
  wire load1 = wr_en & sel_cnt1;

  // read data mux, unused upper bits read as zero
  wire [TGX_DATA_W-1:0] rd_mux =
    sel_ctrl ? TGX_DATA_W'(timer_control_reg) :
    sel_stat ? TGX_DATA_W'(status) :
    sel_mask ? TGX_DATA_W'(mask) :
    sel_cnt0 ? TGX_DATA_W'(count0) :
    sel_cnt1 ? TGX_DATA_W'(count1) :
    sel_pins ? TGX_DATA_W'(pin_level) : '0;

  // ----------------------------------------------------------------
  // interrupt event sources
  // ----------------------------------------------------------------
  wire set_ie0 = irq0_edge_sel ? irq0_fall : ~irq0_level;
  wire set_ie1 = irq1_edge_sel ? irq1_fall : ~irq1_level;

  logic [TGX_STAT_W-1:0] set_vec;
  always_comb begin
    set_vec = '0;
    set_vec[TGX_B_IE0] = set_ie0;
    set_vec[TGX_B_IE1] = set_ie1;
    set_vec[TGX_B_OV0] = evt0.overflow;
    set_vec[TGX_B_OV1] = evt1.overflow;
  end

  wire [TGX_STAT_W-1:0] clr_vec = (wr_en & sel_stat) ? PWDATA[TGX_STAT_W-1:0] : '0;
  // mask as it stands after this edge, so irq never lags a mask write
  wire [TGX_STAT_W-1:0] next_mask = (wr_en & sel_mask) ? PWDATA[TGX_STAT_W-1:0] : mask;
  // a new event wins over a clear in the same cycle
  wire [TGX_STAT_W-1:0] next_status = (status & ~clr_vec) | set_vec;
  wire next_irq = |(next_status & next_mask);

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  tgx_timer #(.CNT_W(TGX_CNT_W)) u_timer0 (
    .clk(CLK),
    .rst(RST),
    .cfg(cfg0),
    .gate_level(irq0_level),
    .count_fall(t0_fall),
    .load(load0),
    .load_value(PWDATA[TGX_CNT_W-1:0]),
    .count(count0),
    .evt(evt0)
  );

  tgx_timer #(.CNT_W(TGX_CNT_W)) u_timer1 (
    .clk(CLK),
    .rst(RST),
    .cfg(cfg1),
    .gate_level(irq1_level),
    .count_fall(t1_fall),
    .load(load1),
    .load_value(PWDATA[TGX_CNT_W-1:0]),
    .count(count1),
    .evt(evt1)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // control and mask writes
  always_ff @(posedge CLK) begin
    if (RST) begin
      timer_control_reg <= TGX_CTRL_RST;
      mask <= TGX_STAT_RST;
    end else begin
      if (wr_en && sel_ctrl) timer_control_reg <= PWDATA[TGX_CTRL_W-1:0];
      mask <= next_mask;
    end
  end

  // sticky status and interrupt output
  always_ff @(posedge CLK) begin
    if (RST) begin
      status <= TGX_STAT_RST;
      IRQ <= 1'b0;
    end else begin
      status <= next_status;
      IRQ <= next_irq;
    end
  end

  // apb answer: one wait state, ready for one cycle
  always_ff @(posedge CLK) begin
    if (RST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= '0;
    end else begin
      PREADY <= access;
      PSLVERR <= access & ~mapped;
      PRDATA <= (access & ~PWRITE) ? rd_mux : '0;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // interrupt 0 flag
  a_edge_sets_ie0: assert property (@(posedge CLK) disable iff (RST)
    (irq0_edge_sel && irq0_fall) |=> status[TGX_B_IE0])
    else $error("ie0 missed a falling edge");
  a_edge_high_quiet: assert property (@(posedge CLK) disable iff (RST)
    (irq0_edge_sel && !irq0_fall && !status[TGX_B_IE0]) |=> !status[TGX_B_IE0])
    else $error("ie0 set without an edge");
  a_level_sets_ie0: assert property (@(posedge CLK) disable iff (RST)
    (!irq0_edge_sel && !irq0_level) |=> status[TGX_B_IE0])
    else $error("ie0 missed a low level");
  a_ie0_sticky: assert property (@(posedge CLK) disable iff (RST)
    (status[TGX_B_IE0] && !clr_vec[TGX_B_IE0]) |=> status[TGX_B_IE0])
    else $error("ie0 dropped without a clear");
  a_ie0_clears: assert property (@(posedge CLK) disable iff (RST)
    (clr_vec[TGX_B_IE0] && !set_ie0) |=> !status[TGX_B_IE0])
    else $error("ie0 survived its clear");

  // interrupt 1 flag
  a_edge_sets_ie1: assert property (@(posedge CLK) disable iff (RST)
    (irq1_edge_sel && irq1_fall) |=> status[TGX_B_IE1])
    else $error("ie1 missed a falling edge");
  a_edge_quiet_ie1: assert property (@(posedge CLK) disable iff (RST)
    (irq1_edge_sel && !irq1_fall && !status[TGX_B_IE1]) |=> !status[TGX_B_IE1])
    else $error("ie1 set without an edge");
  a_level_sets_ie1: assert property (@(posedge CLK) disable iff (RST)
    (!irq1_edge_sel && !irq1_level) |=> status[TGX_B_IE1])
    else $error("ie1 missed a low level");
  a_ie1_sticky: assert property (@(posedge CLK) disable iff (RST)
    (status[TGX_B_IE1] && !clr_vec[TGX_B_IE1]) |=> status[TGX_B_IE1])
    else $error("ie1 dropped without a clear");
  a_ie1_clears: assert property (@(posedge CLK) disable iff (RST)
    (clr_vec[TGX_B_IE1] && !set_ie1) |=> !status[TGX_B_IE1])
    else $error("ie1 survived its clear");

  // gate run control of both timers
  a_timer0_gate_sel_blocks: assert property (@(posedge CLK) disable iff (RST)
    (timer0_gate_sel && !irq0_level && !load0) |=> $stable(count0))
    else $error("timer 0 ran while gate low");
  a_timer1_gate_sel_blocks: assert property (@(posedge CLK) disable iff (RST)
    (timer1_gate_sel && !irq1_level && !load1) |=> $stable(count1))
    else $error("timer 1 ran while gate low");
  a_timer0_gate_sel_runs: assert property (@(posedge CLK) disable iff (RST)
    (cfg0.run && !cfg0.counter_mode && timer0_gate_sel && irq0_level && !load0)
    |=> (count0 == $past(count0) + 1'b1))
    else $error("timer 0 held while gate high");
  a_timer1_gate_sel_runs: assert property (@(posedge CLK) disable iff (RST)
    (cfg1.run && !cfg1.counter_mode && timer1_gate_sel && irq1_level && !load1)
    |=> (count1 == $past(count1) + 1'b1))
    else $error("timer 1 held while gate high");

  // counter mode on the count pins
  a_count0_edge: assert property (@(posedge CLK) disable iff (RST)
    (cfg0.run && cfg0.counter_mode && !timer0_gate_sel && t0_fall && !load0)
    |=> (count0 == $past(count0) + 1'b1))
    else $error("counter 0 missed an edge");
  a_count1_edge: assert property (@(posedge CLK) disable iff (RST)
    (cfg1.run && cfg1.counter_mode && !timer1_gate_sel && t1_fall && !load1)
    |=> (count1 == $past(count1) + 1'b1))
    else $error("counter 1 missed an edge");
  a_count0_quiet: assert property (@(posedge CLK) disable iff (RST)
    (cfg0.counter_mode && !t0_fall && !load0) |=> $stable(count0))
    else $error("counter 0 moved without an edge");
  a_count1_quiet: assert property (@(posedge CLK) disable iff (RST)
    (cfg1.counter_mode && !t1_fall && !load1) |=> $stable(count1))
    else $error("counter 1 moved without an edge");

  // each synchronised falling edge is one pulse
  a_fall_single: assert property (@(posedge CLK) disable iff (RST)
    pin_fall[2] |=> !pin_fall[2])
    else $error("count edge seen twice");
  a_fall_single_t1: assert property (@(posedge CLK) disable iff (RST)
    pin_fall[3] |=> !pin_fall[3])
    else $error("count 1 edge seen twice");
  a_fall_single_i0: assert property (@(posedge CLK) disable iff (RST)
    pin_fall[0] |=> !pin_fall[0])
    else $error("irq 0 edge seen twice");
  a_fall_single_i1: assert property (@(posedge CLK) disable iff (RST)
    pin_fall[1] |=> !pin_fall[1])
    else $error("irq 1 edge seen twice");

  // register file, interrupt output and bus answer
  a_irq_follows: assert property (@(posedge CLK) disable iff (RST)
    IRQ == (|(status & mask)))
    else $error("irq disagrees with unmasked status");
  a_apb_ready: assert property (@(posedge CLK) disable iff (RST)
    (PSEL && PENABLE && !PREADY) |=> PREADY ##1 !PREADY)
    else $error("apb answer not one wait state");
  a_slverr_ready: assert property (@(posedge CLK) disable iff (RST)
    PSLVERR |-> PREADY)
    else $error("error without ready");
  a_slverr_unmapped: assert property (@(posedge CLK) disable iff (RST)
    (access && !mapped) |=> PSLVERR)
    else $error("unmapped access not refused");
  a_rdata_quiet: assert property (@(posedge CLK) disable iff (RST)
    !PREADY |-> (PRDATA == '0))
    else $error("read data outside the ready cycle");
  a_ctrl_write: assert property (@(posedge CLK) disable iff (RST)
    (wr_en && sel_ctrl) |=> (timer_control_reg == $past(PWDATA[TGX_CTRL_W-1:0])))
    else $error("control write lost");
  a_mask_write: assert property (@(posedge CLK) disable iff (RST)
    (wr_en && sel_mask) |=> (mask == $past(PWDATA[TGX_STAT_W-1:0])))
    else $error("mask write lost");
  a_load0_value: assert property (@(posedge CLK) disable iff (RST)
    load0 |=> (count0 == $past(PWDATA[TGX_CNT_W-1:0])))
    else $error("count 0 load lost");
  a_load1_value: assert property (@(posedge CLK) disable iff (RST)
    load1 |=> (count1 == $past(PWDATA[TGX_CNT_W-1:0])))
    else $error("count 1 load lost");
  a_ov0_sets: assert property (@(posedge CLK) disable iff (RST)
    evt0.overflow |=> status[TGX_B_OV0])
    else $error("timer 0 overflow not flagged");
  a_ov1_sets: assert property (@(posedge CLK) disable iff (RST)
    evt1.overflow |=> status[TGX_B_OV1])
    else $error("timer 1 overflow not flagged");

endmodule

// File: pkg/tgx_pkg.sv
/*
  Package for the timer gate and external interrupt input block:
  register offsets, field positions, reset values and carrier types.
  Assumes a 32-bit APB register bus, byte addressing, word-aligned registers.
*/
package tgx_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] TGX_OFF_CTRL = 8'h00;   // timer_control_reg
  localparam logic [7:0] TGX_OFF_STAT = 8'h04;   // sticky event status, write one to clear
  localparam logic [7:0] TGX_OFF_MASK = 8'h08;   // interrupt mask
  localparam logic [7:0] TGX_OFF_CNT0 = 8'h0c;   // timer 0 count
  localparam logic [7:0] TGX_OFF_CNT1 = 8'h10;   // timer 1 count
  localparam logic [7:0] TGX_OFF_PINS = 8'h14;   // synchronised pin levels

  // control register fields
  localparam int TGX_B_RUN0 = 0;
  localparam int TGX_B_CT0 = 1;
  localparam int TGX_B_TIMER0_GATE_SEL = 2;
  localparam int TGX_B_IT0 = 3;
  localparam int TGX_B_RUN1 = 4;
  localparam int TGX_B_CT1 = 5;
  localparam int TGX_B_TIMER1_GATE_SEL = 6;
  localparam int TGX_B_IT1 = 7;
  localparam int TGX_CTRL_W = 8;
  localparam logic [TGX_CTRL_W-1:0] TGX_CTRL_RST = 8'h00;

  // status and mask fields
  localparam int TGX_B_IE0 = 0;
  localparam int TGX_B_IE1 = 1;
  localparam int TGX_B_OV0 = 2;
  localparam int TGX_B_OV1 = 3;
  localparam int TGX_STAT_W = 4;
  localparam logic [TGX_STAT_W-1:0] TGX_STAT_RST = 4'h0;

  localparam int TGX_CNT_W = 16;
  localparam int TGX_DATA_W = 32;
  localparam int TGX_ADDR_W = 8;
  localparam int TGX_SYNC_W = 4;

  // per-timer configuration carrier
  typedef struct packed {
    logic run;
    logic counter_mode;
    logic gate_sel;
  } tgx_tcfg_t;

  // per-timer event carrier toward the register file
  typedef struct packed {
    logic overflow;
  } tgx_tevt_t;

endpackage

// File: tb/tb.sv
/*
  Self-checking bench for the timer gate and external interrupt block.
  Assumes tgx_top with an APB slave, and the pin model on the far side.
*/
`timescale 1ns/1ps
module tb
  import tgx_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [TGX_ADDR_W-1:0] paddr;
  logic [TGX_DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pins;
  int failures, tests_run, i;

  // ----------------------------------------------------------------
  // design and far side
  // ----------------------------------------------------------------
  tgx_top uut (.CLK(clk), .RST(rst), .EXT_IRQ0_IN(pins[0]), .EXT_IRQ1_IN(pins[1]),
    .TIMER0_COUNT_IN(pins[2]), .TIMER1_COUNT_IN(pins[3]), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .IRQ(irq));
  tgx_pin_model pm (.clk(clk), .pins(pins));

  // ----------------------------------------------------------------
  // clock, tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task automatic stop_test;
    $display("mismatches=%0d checks=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    #500000;
    failures++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    tests_run = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    // reset values, pins read back idle high
    for (i = 0; i < 6; i++) rdchk(8'(i * 4), i == 5 ? 32'h0000000f : 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // falling-edge trigger, flag sticky until cleared
    apb(1'b1, TGX_OFF_MASK, 32'h3);
    apb(1'b1, TGX_OFF_CTRL, 32'h88);
    rdchk(TGX_OFF_CTRL, 32'h88);
    for (i = 0; i < 2; i++) begin
      pm.pulse(i, 4);
      repeat (4) @(posedge clk);
      rdchk(TGX_OFF_STAT, 32'(1 << i));
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, TGX_OFF_STAT, 32'(1 << i));
      rdchk(TGX_OFF_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // low-level trigger re-sets the flag while the pin stays low
    apb(1'b1, TGX_OFF_CTRL, 32'h00);
    for (i = 0; i < 2; i++) begin
      pm.drive(i, 1'b0, 6);
      apb(1'b1, TGX_OFF_STAT, 32'(1 << i));
      rdchk(TGX_OFF_STAT, 32'(1 << i));
      apb(1'b1, TGX_OFF_MASK, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, TGX_OFF_MASK, 32'h3);
      pm.drive(i, 1'b1, 6);
      apb(1'b1, TGX_OFF_STAT, 32'(1 << i));
      rdchk(TGX_OFF_STAT, 32'h0);
    end
    // counter mode, one count per falling edge
    apb(1'b1, TGX_OFF_CTRL, 32'h33);
    for (i = 0; i < 2; i++) begin
      repeat (3 + 2 * i) pm.pulse(2 + i, 3);
      repeat (6) @(posedge clk);
      rdchk(TGX_OFF_CNT0 + 8'(4 * i), 32'(3 + 2 * i));
    end
    // counter overflow sets its own status bit, which the mask keeps off irq
    for (i = 0; i < 2; i++) begin
      apb(1'b1, TGX_OFF_CNT0 + 8'(4 * i), 32'h0000ffff);
      pm.pulse(2 + i, 3);
      repeat (6) @(posedge clk);
      rdchk(TGX_OFF_CNT0 + 8'(4 * i), 32'h0);
      rdchk(TGX_OFF_STAT, 32'(1 << (TGX_B_OV0 + i)));
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, TGX_OFF_STAT, 32'h0000000f);
    end
    // gated timer mode: low pin stops, high pin runs
    for (i = 0; i < 2; i++) begin
      pm.drive(i, 1'b0, 3);
      apb(1'b1, TGX_OFF_CTRL, i == 0 ? 32'h05 : 32'h50);
      apb(1'b1, TGX_OFF_CNT0 + 8'(4 * i), 32'h0);
      repeat (10) @(posedge clk);
      rdchk(TGX_OFF_CNT0 + 8'(4 * i), 32'h0);
      pm.drive(i, 1'b1, 6);
      apb(1'b0, TGX_OFF_CNT0 + 8'(4 * i), 32'h0);
      chk({31'h0, rd != 32'h0}, 32'h1);
    end
    stop_test();
  end
endmodule

// File: tb/tgx_pin_model.sv
/*
  Far-side model of the external logic on the interrupt and count pins.
  Assumes one clock shared with the bench; the pins idle high, as with pull-ups.
*/
`timescale 1ns/1ps
module tgx_pin_model (
  input wire logic clk,
  output logic [3:0] pins
);
  // ----------------------------------------------------------------
  // pin driving
  // ----------------------------------------------------------------
  // bit order: irq0, irq1, count0, count1; idle level is high
  initial begin
    pins = 4'hf;
  end

  // hold a pin at a level for n clocks, never for fewer than two
  task automatic drive(input int idx, input logic lvl, input int n);
    @(posedge clk);
    pins[idx] <= lvl;
    repeat (n < 2 ? 2 : n) @(posedge clk);
  endtask

  // one low pulse, then back to the idle level
  task automatic pulse(input int idx, input int n);
    drive(idx, 1'b0, n);
    drive(idx, 1'b1, n);
  endtask
endmodule
